// ===== hdl/grsa_arbiter.sv
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "grsa_consts.svh"
// Notes on behaviour
// R1 - run needs both key selection and contact
// R2 - stop indicator chosen by stop cause
// R3 - peer contact stop forces group stop
// R4 - contact control only for listed codes
// R5 - assignment 1..26, combined variant 12..26; reset loads 1 in either variant
// R6 - group number 0..16, reset 0
// R7 - group zero neither sends nor follows
// R8 - one idle minute discards edit
// R9 - two second shift+set enters, block 10
// R10 - set commits; assign returns, group advances
// R11 - assignment at block 23, group 55
// R12 - operator stops before changing settings
// R13 - contact group control needs combined variant
// R14 - one contact controller per group advised
// R15 - any stop stops all, run unless contact
// R16 - at most 32 controllers on link
// R17 - peer changes applied only on group match
module grsa_arbiter #(
   parameter longint unsigned HOLD_CYCLES = 64'(`GRSA_HOLD_TIME_S) * `GRSA_SYS_CLK_HZ,
   parameter longint unsigned IDLE_CYCLES = 64'(`GRSA_IDLE_TIME_MIN) * 60 * `GRSA_SYS_CLK_HZ
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire grsa_pkg::grsa_keys_t keys_pin,
   input wire logic contact_input,
   input wire logic variant_combined,
   input wire logic [4:0] own_addr,
   input wire logic rx_valid,
   input wire grsa_pkg::grsa_msg_t rx_msg,
   output logic tx_valid,
   output grsa_pkg::grsa_msg_t tx_msg,
   output logic run_state,
   output grsa_pkg::grsa_ind_t indicator,
   output grsa_pkg::grsa_menu_t menu_state,
   output logic [6:0] block_num,
   output logic [4:0] edit_value
);
   import grsa_pkg::*;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic is_run_stop_code(input logic [4:0] code);
      logic [34:0] codes;
      logic hit;
      codes = `GRSA_RUN_STOP_CODES;
      hit = 1'b0;
      for (int i = 0; i < 7; i++) begin
         if (code == codes[5*i +: 5]) hit = 1'b1;
      end
      return hit;
   endfunction

   function automatic logic [4:0] assign_min(input logic combined);
      return combined ? `GRSA_ASSIGN_MIN_COMBINED : `GRSA_ASSIGN_MIN;
   endfunction

   function automatic logic assign_ok(input logic [4:0] code, input logic combined);
      return (code >= assign_min(combined)) && (code <= `GRSA_ASSIGN_MAX);
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [5:0] pin_s1_reg;
   logic [5:0] pin_s2_reg;
   grsa_keys_t keys_now;
   grsa_keys_t keys_prev_reg;
   grsa_keys_t press;
   logic contact_run;
   logic variant_reg;

   // not reset: the strap capture below must see the live pin while srst is high
   always_ff @(posedge sys_clk) begin
      pin_s1_reg <= {variant_combined, contact_input, keys_pin};
      pin_s2_reg <= pin_s1_reg;
   end

   assign keys_now = grsa_keys_t'(pin_s2_reg[3:0]);
   assign contact_run = pin_s2_reg[4];
   assign press = keys_now & ~keys_prev_reg;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         keys_prev_reg <= '0;
      end else begin
         keys_prev_reg <= keys_now;
      end
   end

   // strap kept following the pin during reset, frozen after release
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         variant_reg <= pin_s2_reg[5];
      end
   end

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   logic apb_setup;
   logic apb_wr;
   logic hit_ctrl;
   logic hit_cfg;
   logic hit_status;
   logic hit_peer;
   logic mapped;

   assign hit_ctrl = (paddr == `GRSA_OFS_CTRL);
   assign hit_cfg = (paddr == `GRSA_OFS_CONFIG);
   assign hit_status = (paddr == `GRSA_OFS_STATUS);
   assign hit_peer = (paddr == `GRSA_OFS_PEERMAP);
   assign mapped = hit_ctrl | hit_cfg | hit_status | hit_peer;
   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pwrite && mapped;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ---------------------------------------------------------------
   // settings
   // ---------------------------------------------------------------
   logic [4:0] assign_reg;
   logic [4:0] group_reg;
   logic menu_commit_assign;
   logic menu_commit_group;
   logic [4:0] wr_assign;
   logic [4:0] wr_group;
   logic di_active;
   logic group_en;

   assign wr_assign = pwdata[`GRSA_CFG_ASSIGN_LSB +: 5];
   assign wr_group = pwdata[`GRSA_CFG_GROUP_LSB +: 5];

   // assignment lives at block 23; writes outside the variant's range are dropped
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         assign_reg <= `GRSA_ASSIGN_RESET; // see R5
      end else if (menu_commit_assign) begin
         assign_reg <= edit_value; // see R11
      end else if (apb_wr && hit_cfg && assign_ok(wr_assign, variant_reg)) begin
         assign_reg <= wr_assign; // see R5
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         group_reg <= `GRSA_GROUP_RESET; // see R6
      end else if (menu_commit_group) begin
         group_reg <= edit_value; // see R11
      end else if (apb_wr && hit_cfg && wr_group <= `GRSA_GROUP_MAX) begin
         group_reg <= wr_group; // see R6
      end
   end

   assign di_active = variant_reg && is_run_stop_code(assign_reg); // see R4, R13
   assign group_en = (group_reg != 5'h00); // see R7

   // ---------------------------------------------------------------
   // run/stop arbitration
   // ---------------------------------------------------------------
   logic key_run_reg;
   logic local_cmd;
   logic peer_match;
   logic [31:0] peer_stop_reg;
   logic local_in_stop;
   logic group_stop;
   logic run_next;

   assign local_cmd = apb_wr && hit_ctrl;
   // a peer counts only with the same nonzero group and another address
   assign peer_match = rx_valid && group_en && (rx_msg.group == group_reg)
                       && (rx_msg.addr != own_addr); // see R17

   // local command wins over a peer message landing in the same cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         key_run_reg <= 1'b0;
      end else if (local_cmd) begin
         key_run_reg <= pwdata[`GRSA_CTRL_RUN_BIT];
      end else if (peer_match && rx_msg.kind != MSG_INPUT) begin
         key_run_reg <= (rx_msg.kind == MSG_KEY_RUN); // see R15
      end
   end

   // one bit per link address, so 32 controllers is the hard limit
   always_ff @(posedge sys_clk) begin
      if (srst || !group_en) begin
         peer_stop_reg <= 32'h0000_0000; // see R7
      end else if (rx_valid && rx_msg.kind == MSG_INPUT) begin
         peer_stop_reg[rx_msg.addr] <= peer_match && rx_msg.input_stop; // see R16, R3
      end
   end

   assign local_in_stop = di_active && !contact_run;
   assign group_stop = group_en && (|peer_stop_reg); // see R3, R15
   assign run_next = key_run_reg && !local_in_stop && !group_stop; // see R1

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         run_state <= 1'b0;
      end else begin
         run_state <= run_next;
      end
   end

   // exactly one indicator while stopped, none while running
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         indicator <= '0;
      end else begin
         indicator.stop_indicator <= !key_run_reg && local_in_stop; // see R2
         indicator.key_stop_indicator <= !key_run_reg && !local_in_stop; // see R2
         indicator.input_stop_indicator <= key_run_reg && local_in_stop; // see R2
         indicator.group_input_stop_indicator <= run_next ? 1'b0 :
            (key_run_reg && !local_in_stop); // see R3
      end
   end

   // ---------------------------------------------------------------
   // link transmit
   // ---------------------------------------------------------------
   logic in_stop_prev_reg;
   logic in_pending_reg;
   logic send_input;

   assign send_input = in_pending_reg && !local_cmd;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         in_stop_prev_reg <= 1'b0;
      end else begin
         in_stop_prev_reg <= local_in_stop;
      end
   end

   // a contact change seen while a key message goes out waits one slot
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         in_pending_reg <= 1'b0;
      end else begin
         in_pending_reg <= (local_in_stop != in_stop_prev_reg) || (in_pending_reg && !send_input);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tx_valid <= 1'b0;
         tx_msg <= '0;
      end else begin
         tx_valid <= group_en && (local_cmd || send_input); // see R7
         tx_msg.addr <= own_addr;
         tx_msg.group <= group_reg;
         tx_msg.kind <= local_cmd ? (pwdata[`GRSA_CTRL_RUN_BIT] ? MSG_KEY_RUN : MSG_KEY_STOP)
                                  : MSG_INPUT;
         tx_msg.input_stop <= local_in_stop;
      end
   end

   // ---------------------------------------------------------------
   // front panel menu
   // ---------------------------------------------------------------
   logic hold_restart;
   logic hold_done;
   logic idle_restart;
   logic idle_done;
   logic both_held;
   logic editing;
   logic [4:0] edit_lo;
   logic [4:0] edit_hi;

   assign both_held = keys_now.shift && keys_now.set;
   assign editing = (menu_state == MENU_ASSIGN) || (menu_state == MENU_GROUP);
   assign hold_restart = !(menu_state == MENU_HOLD && both_held);
   assign idle_restart = !editing || (|press);
   assign edit_lo = (menu_state == MENU_ASSIGN) ? assign_min(variant_reg) : 5'h00;
   assign edit_hi = (menu_state == MENU_ASSIGN) ? `GRSA_ASSIGN_MAX : `GRSA_GROUP_MAX;
   assign menu_commit_assign = (menu_state == MENU_ASSIGN) && press.set; // see R10
   assign menu_commit_group = (menu_state == MENU_GROUP) && press.set; // see R10

   grsa_timer #(.W(40)) hold_timer (
      .sys_clk(sys_clk),
      .srst(srst),
      .restart(hold_restart),
      .limit(40'(HOLD_CYCLES)),
      .expired(hold_done)
   );

   grsa_timer #(.W(40)) idle_timer (
      .sys_clk(sys_clk),
      .srst(srst),
      .restart(idle_restart),
      .limit(40'(IDLE_CYCLES)),
      .expired(idle_done)
   );

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         menu_state <= MENU_MONITOR;
         block_num <= `GRSA_BLOCK_FIRST;
         edit_value <= 5'h00;
      end else begin
         unique case (menu_state)
            MENU_MONITOR: begin
               if (both_held) menu_state <= MENU_HOLD;
            end
            MENU_HOLD: begin
               if (!both_held) begin
                  menu_state <= MENU_MONITOR;
               end else if (hold_done) begin
                  menu_state <= MENU_BLOCK; // see R9
                  block_num <= `GRSA_BLOCK_FIRST; // see R9
               end
            end
            MENU_BLOCK: begin
               if (press.set && keys_now.shift) begin
                  menu_state <= MENU_MONITOR;
               end else if (press.set && block_num == `GRSA_BLOCK_ASSIGN) begin
                  menu_state <= MENU_ASSIGN; // see R11
                  edit_value <= assign_reg;
               end else if (press.set && block_num == `GRSA_BLOCK_GROUP) begin
                  menu_state <= MENU_GROUP; // see R11
                  edit_value <= group_reg;
               end else if (press.up && block_num != `GRSA_BLOCK_MAX) begin
                  block_num <= block_num + 7'h01;
               end else if (press.down && block_num != `GRSA_BLOCK_MIN) begin
                  block_num <= block_num - 7'h01;
               end
            end
            MENU_ASSIGN, MENU_GROUP: begin
               if (idle_done) begin
                  menu_state <= MENU_MONITOR; // see R8
               end else if (press.set) begin
                  menu_state <= MENU_BLOCK;
                  block_num <= (menu_state == MENU_ASSIGN) ? `GRSA_BLOCK_ASSIGN
                                                           : `GRSA_BLOCK_GROUP + 7'h01; // see R10
               end else if (press.up && edit_value < edit_hi) begin
                  edit_value <= edit_value + 5'h01;
               end else if (press.down && edit_value > edit_lo) begin
                  edit_value <= edit_value - 5'h01;
               end
            end
            default: begin
               menu_state <= MENU_MONITOR;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // read data, latched in the setup phase
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (apb_setup && !pwrite) begin
         prdata <= 32'h0000_0000;
         if (hit_ctrl) prdata[`GRSA_CTRL_RUN_BIT] <= key_run_reg;
         if (hit_cfg) begin
            prdata[`GRSA_CFG_ASSIGN_LSB +: 5] <= assign_reg;
            prdata[`GRSA_CFG_GROUP_LSB +: 5] <= group_reg;
         end
         if (hit_status) begin
            prdata[0] <= run_state;
            prdata[4:1] <= indicator;
            prdata[5] <= di_active;
            prdata[6] <= contact_run;
            prdata[7] <= variant_reg;
            prdata[12:8] <= menu_state;
            prdata[22:16] <= block_num;
         end
         if (hit_peer) prdata <= peer_stop_reg;
      end
   end
endmodule

// ===== hdl/grsa_consts.svh
`ifndef GRSA_CONSTS_SVH
`define GRSA_CONSTS_SVH

// ---------------------------------------------------------------
// register map (byte addresses, one 32-bit word each)
// ---------------------------------------------------------------
`define GRSA_OFS_CTRL 12'h000
`define GRSA_OFS_CONFIG 12'h004
`define GRSA_OFS_STATUS 12'h008
`define GRSA_OFS_PEERMAP 12'h00c

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define GRSA_CTRL_RUN_BIT 0
`define GRSA_CFG_ASSIGN_LSB 0
`define GRSA_CFG_GROUP_LSB 8

// ---------------------------------------------------------------
// setting ranges and reset values
// ---------------------------------------------------------------
`define GRSA_ASSIGN_RESET 5'h01
`define GRSA_ASSIGN_MIN 5'h01
`define GRSA_ASSIGN_MIN_COMBINED 5'h0c
`define GRSA_ASSIGN_MAX 5'h1a
`define GRSA_GROUP_RESET 5'h00
`define GRSA_GROUP_MAX 5'h10
`define GRSA_RUN_STOP_CODES {5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h12, 5'h13, 5'h17}

// ---------------------------------------------------------------
// menu block numbers
// ---------------------------------------------------------------
`define GRSA_BLOCK_FIRST 7'h0a
`define GRSA_BLOCK_ASSIGN 7'h17
`define GRSA_BLOCK_GROUP 7'h37
`define GRSA_BLOCK_MIN 7'h01
`define GRSA_BLOCK_MAX 7'h63

// ---------------------------------------------------------------
// timing and link size
// ---------------------------------------------------------------
`define GRSA_SYS_CLK_HZ 200000000
`define GRSA_HOLD_TIME_S 2
`define GRSA_IDLE_TIME_MIN 1
`define GRSA_PEERS_MAX 32

`endif

// ===== hdl/grsa_pkg.sv
package grsa_pkg;

   typedef enum logic [4:0] {
      MENU_MONITOR = 5'b00001,
      MENU_HOLD = 5'b00010,
      MENU_BLOCK = 5'b00100,
      MENU_ASSIGN = 5'b01000,
      MENU_GROUP = 5'b10000
   } grsa_menu_t;

   typedef enum logic [1:0] {
      MSG_KEY_STOP = 2'h0,
      MSG_KEY_RUN = 2'h1,
      MSG_INPUT = 2'h2
   } grsa_kind_t;

   typedef struct packed {
      logic [4:0] addr;
      logic [4:0] group;
      grsa_kind_t kind;
      logic input_stop;
   } grsa_msg_t;

   typedef struct packed {
      logic stop_indicator;
      logic key_stop_indicator;
      logic input_stop_indicator;
      logic group_input_stop_indicator;
   } grsa_ind_t;

   typedef struct packed {
      logic shift;
      logic set;
      logic up;
      logic down;
   } grsa_keys_t;

endpackage

// ===== hdl/grsa_timer.sv
`timescale 1ns/10ps
module grsa_timer #(
   parameter int W = 40
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic restart,
   input wire logic [W-1:0] limit,
   output logic expired
);
   logic [W-1:0] count_reg;

   // counts while not restarted; saturates at the limit so expired stays a level
   always_ff @(posedge sys_clk) begin
      if (srst || restart) begin
         count_reg <= '0;
      end else if (count_reg != limit) begin
         count_reg <= count_reg + 1'b1;
      end
   end

   assign expired = (count_reg == limit) && !restart;
endmodule

// ===== verif/grsa_arbiter_monitor.sv
`timescale 1ns/10ps
`include "grsa_consts.svh"
module grsa_arbiter_monitor #(
   parameter longint unsigned HOLD_CYCLES = 20,
   parameter longint unsigned IDLE_CYCLES = 50
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire grsa_pkg::grsa_keys_t keys_pin,
   input wire logic tx_valid,
   input wire grsa_pkg::grsa_msg_t tx_msg,
   input wire logic run_state,
   input wire grsa_pkg::grsa_ind_t indicator,
   input wire grsa_pkg::grsa_menu_t menu_state,
   input wire logic [6:0] block_num,
   input wire logic [4:0] edit_value
);
   import grsa_pkg::*;
   // ---------------------------------------------------------------
   // helper counters
   // ---------------------------------------------------------------
   longint unsigned hold_cnt;
   longint unsigned idle_cnt;
   grsa_keys_t keys_q;
   always_ff @(posedge sys_clk) begin
      keys_q <= keys_pin;
   end
   always_ff @(posedge sys_clk) begin
      if (srst || menu_state != MENU_HOLD) hold_cnt <= 0;
      else hold_cnt <= hold_cnt + 1;
   end
   // restarts on any key change at the pin, so after a press it runs two cycles ahead of the design's own timer
   always_ff @(posedge sys_clk) begin
      if (srst || keys_pin != keys_q || !(menu_state inside {MENU_ASSIGN, MENU_GROUP}))
         idle_cnt <= 0;
      else idle_cnt <= idle_cnt + 1;
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence s_to_block(grsa_menu_t from);
      $past(menu_state) == from && menu_state == MENU_BLOCK;
   endsequence
   property p_run_dark; run_state && $past(run_state) |-> indicator == 4'h0; endproperty
   a_run_dark: assert property (p_run_dark) else $error("indicator lit while running");
   property p_one_ind; $onehot0(indicator); endproperty
   a_one_ind: assert property (p_one_ind) else $error("two stop indicators lit");
   property p_tx_group; tx_valid |-> tx_msg.group != 5'h00; endproperty
   a_tx_group: assert property (p_tx_group) else $error("sent with group zero");
   property p_first_blk; s_to_block(MENU_HOLD) |-> block_num == `GRSA_BLOCK_FIRST; endproperty
   a_first_blk: assert property (p_first_blk) else $error("wrong first block");
   property p_hold; s_to_block(MENU_HOLD) |-> $past(hold_cnt) + 2 >= HOLD_CYCLES; endproperty
   a_hold: assert property (p_hold) else $error("entered before hold time");
   property p_asg_back; s_to_block(MENU_ASSIGN) |-> block_num == `GRSA_BLOCK_ASSIGN; endproperty
   a_asg_back: assert property (p_asg_back) else $error("wrong block after assign");
   property p_grp_next; s_to_block(MENU_GROUP) |-> block_num == 7'h38; endproperty
   a_grp_next: assert property (p_grp_next) else $error("wrong block after group");
   property p_asg_site;
      $past(menu_state) == MENU_BLOCK && menu_state == MENU_ASSIGN |->
         $past(block_num) == `GRSA_BLOCK_ASSIGN;
   endproperty
   a_asg_site: assert property (p_asg_site) else $error("assign edit at wrong block");
   property p_asg_span; menu_state == MENU_ASSIGN |-> edit_value inside {[5'h01:5'h1a]}; endproperty
   a_asg_span: assert property (p_asg_span) else $error("assign edit out of range");
   property p_grp_span; menu_state == MENU_GROUP |-> edit_value <= `GRSA_GROUP_MAX; endproperty
   a_grp_span: assert property (p_grp_span) else $error("group edit out of range");
   property p_idle; idle_cnt <= IDLE_CYCLES + 8; endproperty
   a_idle: assert property (p_idle) else $error("edit outlived idle time");
   c_grp_edit: cover property (menu_state == MENU_GROUP);
   c_grp_stop: cover property (indicator.group_input_stop_indicator);
   c_tx_input: cover property (tx_valid && tx_msg.kind == MSG_INPUT);
endmodule

// ===== verif/grsa_peer_model.sv
`timescale 1ns/10ps
module grsa_peer_model (
   input wire logic sys_clk,
   output logic rx_valid,
   output grsa_pkg::grsa_msg_t rx_msg,
   input wire logic tx_valid,
   input wire grsa_pkg::grsa_msg_t tx_msg
);
   import grsa_pkg::*;
   int tx_cnt = 0;
   grsa_msg_t last_tx = '0;
   initial begin
      rx_valid = 1'b0;
      rx_msg = '0;
   end
   always @(posedge sys_clk) begin
      if (tx_valid === 1'b1) begin
         tx_cnt <= tx_cnt + 1;
         last_tx <= tx_msg;
      end
   end
   // five address bits leave room for no more than 32 members
   task automatic send(input grsa_msg_t m);
      rx_valid <= 1'b1;
      rx_msg <= m;
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      // idle bus shows the inverse so a stale word is never taken for a message
      rx_msg <= ~m;
      @(posedge sys_clk);
   endtask
endmodule

// ===== verif/grsa_arbiter_test.sv
`timescale 1ns/10ps
`include "grsa_consts.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module grsa_arbiter_test;
   import grsa_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err, rx_valid, tx_valid, run_state;
   grsa_keys_t keys_pin = '0;
   logic contact_input = 1'b1, variant_combined = 1'b0;
   logic [4:0] own_addr = 5'h01;
   grsa_msg_t rx_msg, tx_msg;
   grsa_ind_t indicator;
   grsa_menu_t menu_state;
   logic [6:0] block_num;
   logic [4:0] edit_value;
   int failures = 0, checks_done = 0, n;
   grsa_msg_t msgs [6] = '{{5'h05, 5'h03, 2'h2, 1'b1}, {5'h05, 5'h03, 2'h2, 1'b0},
      {5'h06, 5'h04, 2'h2, 1'b1}, {5'h01, 5'h03, 2'h0, 1'b0}, {5'h07, 5'h03, 2'h0, 1'b0},
      {5'h07, 5'h03, 2'h1, 1'b0}};
   logic [4:0] res [6] = '{5'h01, 5'h10, 5'h10, 5'h10, 5'h04, 5'h10};
   always #2.5 sys_clk = ~sys_clk;
   grsa_arbiter #(.HOLD_CYCLES(20), .IDLE_CYCLES(50)) i_grsa_arbiter (.sys_clk, .srst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .keys_pin,
      .contact_input, .variant_combined, .own_addr, .rx_valid, .rx_msg, .tx_valid, .tx_msg,
      .run_state, .indicator, .menu_state, .block_num, .edit_value);
   grsa_peer_model i_grsa_peer_model (.sys_clk, .rx_valid, .rx_msg, .tx_valid, .tx_msg);
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   task automatic reboot;
      srst <= 1'b1;
      cyc(20);
      srst <= 1'b0;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         failures++;
         give_verdict();
      end
      @(posedge sys_clk);
   endtask
   task automatic press(input grsa_keys_t k, input int hold);
      keys_pin <= k;
      cyc(hold);
      keys_pin <= '0;
      cyc(4);
   endtask
   function automatic logic ctl(input int c);
      return c inside {13, 14, 15, 17, 18, 19, 23};
   endfunction
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      reboot();
      apb(0, `GRSA_OFS_CONFIG, 0);
      `CHK(rd, 32'h1)
      apb(0, 12'h010, 0);
      `CHK({err, rd}, 33'h100000000)
      apb(1, `GRSA_OFS_CONFIG, 32'hd);
      apb(1, `GRSA_OFS_CONFIG, 32'h1b);
      apb(0, `GRSA_OFS_CONFIG, 0);
      `CHK(rd, 32'hd)
      contact_input <= 1'b0;
      apb(1, `GRSA_OFS_CTRL, 1);
      cyc(8);
      `CHK(run_state, 1'b1)
      variant_combined <= 1'b1;
      reboot();
      apb(1, `GRSA_OFS_CONFIG, 32'h0b);
      apb(1, `GRSA_OFS_CONFIG, 32'h1100);
      apb(0, `GRSA_OFS_CONFIG, 0);
      `CHK(rd, 32'h1)
      for (int c = 12; c <= 26; c++) begin
         apb(1, `GRSA_OFS_CTRL, 0);
         apb(1, `GRSA_OFS_CONFIG, c);
         apb(1, `GRSA_OFS_CTRL, 1);
         cyc(8);
         `CHK(run_state, !ctl(c))
         `CHK(indicator, ctl(c) ? 4'h2 : 4'h0)
      end
      apb(1, `GRSA_OFS_CTRL, 0);
      apb(1, `GRSA_OFS_CONFIG, 32'h17);
      for (int i = 0; i < 4; i++) begin
         contact_input <= i[0];
         apb(1, `GRSA_OFS_CTRL, i[1]);
         cyc(8);
         `CHK({run_state, indicator}, (i == 3) ? 5'h10 : 5'h08 >> i)
      end
      apb(1, `GRSA_OFS_CTRL, 0);
      apb(1, `GRSA_OFS_CONFIG, 32'h317);
      n = i_grsa_peer_model.tx_cnt;
      apb(1, `GRSA_OFS_CTRL, 1);
      cyc(6);
      `CHK(i_grsa_peer_model.tx_cnt, n + 1)
      `CHK(i_grsa_peer_model.last_tx, {5'h01, 5'h03, MSG_KEY_RUN, 1'b0})
      // peers carry contact state as a lone contact-controlled member would
      for (int i = 0; i < 6; i++) begin
         i_grsa_peer_model.send(msgs[i]);
         cyc(4);
         `CHK({run_state, indicator}, res[i])
         if (i == 0) begin
            apb(0, `GRSA_OFS_PEERMAP, 0);
            `CHK(rd, 32'h20)
         end
      end
      apb(0, `GRSA_OFS_STATUS, 0);
      `CHK(rd, 32'h000a01e1)
      contact_input <= 1'b0;
      cyc(8);
      `CHK(i_grsa_peer_model.last_tx, {5'h01, 5'h03, MSG_INPUT, 1'b1})
      apb(1, `GRSA_OFS_CTRL, 0);
      apb(1, `GRSA_OFS_CONFIG, 32'h17);
      contact_input <= 1'b1;
      n = i_grsa_peer_model.tx_cnt;
      apb(1, `GRSA_OFS_CTRL, 1);
      i_grsa_peer_model.send(msgs[0]);
      cyc(4);
      `CHK({run_state, i_grsa_peer_model.tx_cnt}, {1'b1, n})
      apb(1, `GRSA_OFS_CTRL, 0);
      press(4'hc, 10);
      `CHK(menu_state, MENU_MONITOR)
      press(4'hc, 30);
      `CHK({menu_state, block_num}, {MENU_BLOCK, 7'h0a})
      repeat (13) press(4'h2, 2);
      press(4'h4, 2);
      `CHK(menu_state, MENU_ASSIGN)
      press(4'h1, 2);
      press(4'h4, 2);
      `CHK({menu_state, block_num}, {MENU_BLOCK, 7'h17})
      repeat (32) press(4'h2, 2);
      press(4'h4, 2);
      `CHK(menu_state, MENU_GROUP)
      repeat (17) press(4'h2, 2);
      `CHK(edit_value, 5'h10)
      press(4'h4, 2);
      `CHK(block_num, 7'h38)
      apb(0, `GRSA_OFS_CONFIG, 0);
      `CHK(rd, 32'h1016)
      press(4'h1, 2);
      press(4'h4, 2);
      press(4'h1, 2);
      cyc(60);
      `CHK(menu_state, MENU_MONITOR)
      apb(0, `GRSA_OFS_CONFIG, 0);
      `CHK(rd, 32'h1016)
      give_verdict();
   end
endmodule
bind grsa_arbiter grsa_arbiter_monitor #(.HOLD_CYCLES(HOLD_CYCLES), .IDLE_CYCLES(IDLE_CYCLES))
   i_grsa_arbiter_monitor (.sys_clk, .srst, .keys_pin, .tx_valid, .tx_msg, .run_state,
   .indicator, .menu_state, .block_num, .edit_value);
